// ===== design/evp_pkg.sv
// Purpose: shared constants and carriers for the exception vector prioritizer
// Assumes: 16-bit vector addresses, 32-bit AXI4-Lite register access
// Notes:   vector low bytes are offsets from the 256-byte aligned vector base
package evp_pkg;
   // ****************************************************************
   // register map
   // ****************************************************************
   localparam logic [7:0]  OFF_VBASE    = 8'h00;
   localparam logic [7:0]  OFF_STATUS   = 8'h04;
   localparam logic [7:0]  VBASE_RST    = 8'hff;
   localparam logic [7:0]  DEBUG_BASE   = 8'hff;
   localparam logic [7:0]  BASE_LOW     = 8'h00;
   localparam int          STAT_PEND_B  = 16;
   localparam int          STAT_WAKE_B  = 17;
   localparam logic [1:0]  RESP_OKAY    = 2'b00;
   localparam logic [1:0]  RESP_SLVERR  = 2'b10;

   // ****************************************************************
   // vectors
   // ****************************************************************
   localparam logic [15:0] VEC_RST_MAIN = 16'hfffe;
   localparam logic [15:0] VEC_RST_CLKM = 16'hfffc;
   localparam logic [15:0] VEC_RST_WDOG = 16'hfffa;
   localparam logic [7:0]  LOW_TRAP     = 8'hf8;
   localparam logic [7:0]  LOW_SWTRAP   = 8'hf6;
   localparam logic [7:0]  LOW_HIGH     = 8'hf4;
   localparam logic [7:0]  LOW_PIN      = 8'hf2;
   localparam logic [7:0]  LOW_DEV_MIN  = 8'h82;
   localparam logic [7:0]  LOW_SPUR     = 8'h80;
   localparam int          NUM_DEV_DEF  = 56;

   typedef struct packed {
      logic mainRst;
      logic clkMonRst;
      logic watchdogRst;
   } evp_rst_req_t;

   typedef struct packed {
      logic trap;
      logic softwareTrapCall;
      logic highClassPinRequest;
      logic interDieLinkError;
      logic pinIrq;
   } evp_core_req_t;

   typedef struct packed {
      logic iMask;
      logic xMask;
      logic debugActive;
      logic waitMode;
      logic stopMode;
   } evp_cpu_flags_t;
endpackage : evp_pkg

// ===== design/evp_prioritizer.sv
// Purpose: picks the winning exception and hands its vector to the cpu
// Assumes: all request inputs synchronous to clk; clk stops in stop/wait
// Notes:   vector is latched on the fetch strobe and valid one cycle later
//
// Overview of operation
// - higher vector address wins among pending requests
// - ordinary request needs enable, clear mask, no blockers
// - non-ordinary exceptions beat every ordinary request
// - high-class request preempts ordinary routine when unmasked
// - priority resolved at the cpu vector fetch
// - nothing active gives spurious vector base+0x80
// - fixed reset vectors fffe, fffc, fffa first
// - trap at base+f8, then software trap f6
// - high-class at base+f4, pin at base+f2
// - device sources f0 down to 82, larger wins
// - resets, trap, swtrap, high, pin, device, spurious
// - every driven vector is full 16 bits
// - high-class serves link error or dedicated pin
// - ordinary wake allowed only with mask clear
// - ordinary stop wake only from asynchronous-capable sources
// - high-class wakes regardless of its mask
// - masked high-class wake resumes without routine
// - ordinary nesting only after mask cleared
// - vector base is register byte plus zero
// - vector base register resets to all ones
// - debug active forces base upper byte ones
//
// The register addresses and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module evp_prioritizer #(
   parameter int              NUM_DEV    = evp_pkg::NUM_DEV_DEF,
   parameter bit              HAS_LINK   = 1'b0,
   parameter bit              PIN_ASYNC  = 1'b1,
   parameter logic [NUM_DEV-1:0] DEV_ASYNC = '0,
   parameter int              ADDR_W     = 8
) (
   input  wire logic                   clk,
   input  wire logic                   srst,
   input  wire evp_pkg::evp_rst_req_t  rstReq,
   input  wire evp_pkg::evp_core_req_t coreReq,
   input  wire evp_pkg::evp_cpu_flags_t cpuFlags,
   input  wire logic [NUM_DEV-1:0]     devReq,
   input  wire logic [NUM_DEV-1:0]     devLocalEn,
   input  wire logic                   vecFetch,
   output logic [15:0]                 vector_q,
   output logic                        vecValid_q,
   output logic                        intReq_q,
   output logic                        wake_q,
   output logic                        resumeNoService_q,
   input  wire logic [ADDR_W-1:0]      s_axi_awaddr,
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   output logic [1:0]                  s_axi_bresp,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   input  wire logic [ADDR_W-1:0]      s_axi_araddr,
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   output logic [31:0]                 s_axi_rdata,
   output logic [1:0]                  s_axi_rresp,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready
);
   import evp_pkg::*;

   logic [7:0]         vbase_q;
   logic [15:0]        lastVec_q;
   logic               lastPend_q;
   logic [ADDR_W-1:0]  awAddr_q;
   logic               awHeld_q;
   logic [31:0]        wData_q;
   logic [3:0]         wStrb_q;
   logic               wHeld_q;

   logic               highReq;
   logic [NUM_DEV-1:0] devQual;
   logic               devHit;
   logic [7:0]         devLow;
   logic               ordOk;
   logic [7:0]         base;
   logic [15:0]        vecD;
   logic               pendD;
   logic               ordWake;
   logic               wakeD;
   logic               doWrite;

   // ****************************************************************
   // priority decode
   // ****************************************************************
   always_comb begin
      highReq = HAS_LINK ? coreReq.interDieLinkError : coreReq.highClassPinRequest;
      devQual = devReq & devLocalEn;
      devHit  = 1'b0;
      devLow  = LOW_SPUR;
      for (int i = 0; i < NUM_DEV; i++) begin
         if (devQual[i]) begin
            devHit = 1'b1;
            devLow = LOW_DEV_MIN + 8'(2 * i);
         end
      end
      ordOk = ~cpuFlags.iMask & ~coreReq.trap & ~coreReq.softwareTrapCall & ~highReq;
      base = cpuFlags.debugActive ? DEBUG_BASE : vbase_q;
      pendD = 1'b1;
      if (rstReq.mainRst) begin
         vecD = VEC_RST_MAIN;
      end else if (rstReq.clkMonRst) begin
         vecD = VEC_RST_CLKM;
      end else if (rstReq.watchdogRst) begin
         vecD = VEC_RST_WDOG;
      end else if (coreReq.trap) begin
         vecD = {base, LOW_TRAP};
      end else if (coreReq.softwareTrapCall) begin
         vecD = {base, LOW_SWTRAP};
      // high-class gated only by its own mask
      end else if (highReq && !cpuFlags.xMask) begin
         vecD = {base, LOW_HIGH};
      end else if (coreReq.pinIrq && ordOk) begin
         vecD = {base, LOW_PIN};
      end else if (devHit && ordOk) begin
         vecD = {base, devLow};
      end else begin
         vecD  = {base, LOW_SPUR};
         pendD = 1'b0;
      end
   end

   // ****************************************************************
   // wake-up qualification
   // ****************************************************************
   always_comb begin
      if (cpuFlags.stopMode) begin
         ordWake = (coreReq.pinIrq & PIN_ASYNC) | (|(devQual & DEV_ASYNC));
      end else begin
         ordWake = coreReq.pinIrq | devHit;
      end
      ordWake = ordWake & ~cpuFlags.iMask;
      wakeD = (cpuFlags.stopMode | cpuFlags.waitMode) & (ordWake | highReq);
   end

   // ****************************************************************
   // cpu-facing outputs
   // ****************************************************************
   // resolved at fetch, not at request
   // decode settles within the fetch cycle
   always_ff @(posedge clk) begin
      if (srst) begin
         vector_q   <= VEC_RST_MAIN;
         vecValid_q <= 1'b0;
         lastVec_q  <= VEC_RST_MAIN;
         lastPend_q <= 1'b0;
      end else begin
         vecValid_q <= vecFetch;
         if (vecFetch) begin
            vector_q   <= vecD;
            lastVec_q  <= vecD;
            lastPend_q <= pendD;
         end
      end
   end

   // limitation: flops here freeze with clk; the cpu side must treat these
   // as levels held while asleep, the clock domain wakes on wake_q
   always_ff @(posedge clk) begin
      if (srst) begin
         intReq_q          <= 1'b0;
         wake_q            <= 1'b0;
         resumeNoService_q <= 1'b0;
      end else begin
         intReq_q <= (highReq & ~cpuFlags.xMask)
                   | ((coreReq.pinIrq | devHit) & ordOk);
         wake_q   <= wakeD;
         // masked high-class wake skips the routine
         // relies on line held until resume
         resumeNoService_q <= wakeD & highReq & cpuFlags.xMask & ~ordWake;
      end
   end

   // ****************************************************************
   // axi4-lite write path
   // ****************************************************************
   assign doWrite = awHeld_q & wHeld_q & ~s_axi_bvalid;

   always_ff @(posedge clk) begin
      if (srst) begin
         awHeld_q      <= 1'b0;
         awAddr_q      <= '0;
         s_axi_awready <= 1'b0;
      end else begin
         s_axi_awready <= ~awHeld_q & ~s_axi_awready & s_axi_awvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld_q <= 1'b1;
            awAddr_q <= s_axi_awaddr;
         end else if (doWrite) begin
            awHeld_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         wHeld_q      <= 1'b0;
         wData_q      <= '0;
         wStrb_q      <= '0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_wready <= ~wHeld_q & ~s_axi_wready & s_axi_wvalid;
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld_q <= 1'b1;
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
         end else if (doWrite) begin
            wHeld_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (doWrite) begin
         s_axi_bvalid <= 1'b1;
         // status is read-only, so a write there is refused too
         s_axi_bresp  <= (awAddr_q == ADDR_W'(OFF_VBASE)) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         vbase_q <= VBASE_RST;
      end else if (doWrite && awAddr_q == ADDR_W'(OFF_VBASE) && wStrb_q[0]) begin
         vbase_q <= wData_q[7:0];
      end
   end

   // ****************************************************************
   // axi4-lite read path
   // ****************************************************************
   always_ff @(posedge clk) begin
      if (srst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= RESP_OKAY;
      end else begin
         s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            s_axi_rdata  <= '0;
            if (s_axi_araddr == ADDR_W'(OFF_VBASE)) begin
               s_axi_rdata[7:0] <= vbase_q;
            end else if (s_axi_araddr == ADDR_W'(OFF_STATUS)) begin
               s_axi_rdata[15:0]        <= lastVec_q;
               s_axi_rdata[STAT_PEND_B] <= lastPend_q;
               s_axi_rdata[STAT_WAKE_B] <= wake_q;
            end else begin
               s_axi_rresp <= RESP_SLVERR;
            end
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // sources hold requests; a dropped one yields spurious
endmodule : evp_prioritizer

// ===== testbench/evp_cpu_model.sv
// Purpose: cpu side that fetches vectors from the prioritizer
// Assumes: answer arrives the cycle after the fetch edge
// Notes:   idle count lets a test fetch late; with zero idle, fetch strobes come every second cycle
`timescale 1ns/1ps
module evp_cpu_model (
   input  wire logic        clk,
   input  wire logic [15:0] vector_q,
   input  wire logic        vecValid_q,
   output logic             vecFetch
);
   initial vecFetch = 1'b0;
   task automatic fetch(input int idle, output logic [15:0] vec, output logic ok);
      repeat (idle) @(posedge clk);
      vecFetch <= 1'b1;
      @(posedge clk);
      vecFetch <= 1'b0;
      @(posedge clk);
      vec = vector_q;
      ok = vecValid_q;
   endtask : fetch
endmodule : evp_cpu_model

// ===== testbench/evp_prioritizer_checker.sv
// Purpose: port-level assertions for the exception vector prioritizer
// Assumes: HAS_LINK=0, so the pin is the high-class source
// Notes:   bound to every prioritizer instance
`timescale 1ns/1ps
module evp_prioritizer_checker
   import evp_pkg::*;
#(
   parameter int NUM_DEV = 56
) (
   input wire logic                    clk,
   input wire logic                    srst,
   input wire evp_pkg::evp_rst_req_t   rstReq,
   input wire evp_pkg::evp_core_req_t  coreReq,
   input wire evp_pkg::evp_cpu_flags_t cpuFlags,
   input wire logic [NUM_DEV-1:0]      devReq,
   input wire logic [NUM_DEV-1:0]      devLocalEn,
   input wire logic                    vecFetch,
   input wire logic [15:0]             vector_q,
   input wire logic                    vecValid_q,
   input wire logic                    wake_q
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   // ****
   // fetch answers
   // ****
   a_fetch_answer: assert property (vecFetch |=> vecValid_q)
      else $error("no valid after fetch");
   a_no_stray: assert property (!vecFetch |=> !vecValid_q && $stable(vector_q))
      else $error("vector moved without fetch");
   a_main_reset: assert property (vecFetch && rstReq.mainRst |=> vector_q == 16'hfffe)
      else $error("main reset vector wrong");
   a_wdog_reset: assert property (vecFetch && rstReq == 3'b001 |=> vector_q == 16'hfffa)
      else $error("watchdog reset vector wrong");
   a_trap_first: assert property (vecFetch && rstReq == 3'b000 && coreReq.trap
      |=> vector_q[7:0] == 8'hf8) else $error("trap not chosen");
   a_debug_base: assert property (vecFetch && rstReq == 3'b000 && cpuFlags.debugActive
      |=> vector_q[15:8] == 8'hff) else $error("debug base not forced");
   a_spurious_vec: assert property (vecFetch && rstReq == 3'b000 && coreReq == 5'h00
      && (devReq & devLocalEn) == '0 |=> vector_q[7:0] == 8'h80) else $error("no spurious");
   // ****
   // wake
   // ****
   a_masked_wake: assert property (cpuFlags.iMask && !coreReq.highClassPinRequest
      |=> !wake_q) else $error("masked wake");
   a_high_wake: assert property ((cpuFlags.waitMode || cpuFlags.stopMode)
      && coreReq.highClassPinRequest |=> wake_q) else $error("high-class did not wake");
endmodule : evp_prioritizer_checker

bind evp_prioritizer evp_prioritizer_checker #(.NUM_DEV(NUM_DEV)) chk_u (
   .clk(clk), .srst(srst), .rstReq(rstReq), .coreReq(coreReq), .cpuFlags(cpuFlags),
   .devReq(devReq), .devLocalEn(devLocalEn), .vecFetch(vecFetch),
   .vector_q(vector_q), .vecValid_q(vecValid_q), .wake_q(wake_q));

// ===== testbench/exception_vector_prioritizer_tb.sv
// Purpose: self-checking bench for the exception vector prioritizer
// Assumes: default parameters, base set over the register bus
// Notes:   device request bit 0 alone, and bits 55 and 3 together, hit the priority edges
`timescale 1ns/1ps
module exception_vector_prioritizer_tb;
   import evp_pkg::*;
   logic clk = 1'b0;
   logic srst = 1'b1;
   evp_rst_req_t rstReq = '0;
   evp_core_req_t coreReq = '0;
   evp_cpu_flags_t cpuFlags = '0;
   logic [55:0] devReq = '0, devLocalEn = '1;
   logic [15:0] vector_q;
   logic vecFetch, vecValid_q, intReq_q, wake_q, resumeNoService_q;
   logic [7:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata;
   logic [3:0] wstrb = '0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   int bad_count = 0, checks_done = 0, cyc = 0;
   always #12.5 clk = ~clk;
   evp_prioritizer dut_u (.clk(clk), .srst(srst), .rstReq(rstReq), .coreReq(coreReq),
      .cpuFlags(cpuFlags), .devReq(devReq), .devLocalEn(devLocalEn), .vecFetch(vecFetch),
      .vector_q(vector_q), .vecValid_q(vecValid_q), .intReq_q(intReq_q), .wake_q(wake_q),
      .resumeNoService_q(resumeNoService_q), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   evp_cpu_model cpu_u (.clk(clk), .vector_q(vector_q), .vecValid_q(vecValid_q),
      .vecFetch(vecFetch));
   // ****
   // tasks
   // ****
   task automatic print_verdict();
      if (bad_count == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : print_verdict
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   task automatic axw(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d,
                      input logic [1:0] e);
      logic done;
      done = 1'b0;
      awaddr <= a;
      wstrb <= s;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      // loop on a local flag: bready only takes its new value after this step
      while (!done) begin
         @(posedge clk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1) begin
            bready <= 1'b0;
            cmp(32'(bresp), 32'(e));
            done = 1'b1;
            @(posedge clk);
         end
      end
   endtask : axw
   task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
      logic done;
      done = 1'b0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!done) begin
         @(posedge clk);
         if (arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1) begin
            rready <= 1'b0;
            cmp({rdata[31:2], rresp}, {d[31:2], e});
            cmp(32'(rdata[1:0]), 32'(d[1:0]));
            done = 1'b1;
            @(posedge clk);
         end
      end
   endtask : axr
   task automatic fv(input logic [4:0] c, input logic [4:0] f, input logic [55:0] d,
                     input logic [15:0] e);
      logic [15:0] v;
      logic ok;
      coreReq <= c;
      cpuFlags <= f;
      devReq <= d;
      cpu_u.fetch(0, v, ok);
      cmp(32'({ok, v}), 32'({1'b1, e}));
   endtask : fv
   task automatic wk(input logic [4:0] c, input logic [4:0] f, input logic [55:0] d,
                     input logic [2:0] e);
      coreReq <= c;
      cpuFlags <= f;
      devReq <= d;
      repeat (2) @(posedge clk);
      cmp(32'({intReq_q, wake_q, resumeNoService_q}), 32'(e));
   endtask : wk
   task automatic rst();
      srst <= 1'b1;
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      cmp(32'(vector_q), 32'hfffe);
   endtask : rst
   // ****
   // sequence
   // ****
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         bad_count++;
         print_verdict();
      end
   end
   initial begin
      rst();
      axr(8'h00, 32'hff, RESP_OKAY);
      axw(8'h00, 4'hf, 32'h12, RESP_OKAY);
      axw(8'h00, 4'h0, 32'h34, RESP_OKAY);
      axw(OFF_STATUS, 4'hf, 32'h56, RESP_SLVERR);
      axr(8'h00, 32'h12, RESP_OKAY);
      axr(8'h08, 32'h0, RESP_SLVERR);
      rstReq <= 3'b111;
      fv(5'h1f, 5'h00, '1, 16'hfffe);
      rstReq <= 3'b011;
      fv(5'h1f, 5'h04, '1, 16'hfffc);
      rstReq <= 3'b001;
      fv(5'h1f, 5'h00, '1, 16'hfffa);
      rstReq <= 3'b000;
      fv(5'h1f, 5'h00, '1, 16'h12f8);
      fv(5'h0f, 5'h00, '1, 16'h12f6);
      fv(5'h07, 5'h10, '1, 16'h12f4);
      fv(5'h01, 5'h00, '1, 16'h12f2);
      axr(OFF_STATUS, 32'h0001_12f2, RESP_OKAY);
      fv(5'h00, 5'h00, {1'b1, 51'h0, 4'h8}, 16'h12f0);
      fv(5'h00, 5'h00, 56'h1, 16'h1282);
      fv(5'h00, 5'h10, '1, 16'h1280);
      fv(5'h04, 5'h08, '1, 16'h1280);
      fv(5'h02, 5'h00, '0, 16'h1280);
      devLocalEn <= '0;
      fv(5'h00, 5'h00, '1, 16'h1280);
      devLocalEn <= '1;
      axr(OFF_STATUS, 32'h1280, RESP_OKAY);
      fv(5'h00, 5'h04, '0, 16'hff80);
      wk(5'h01, 5'h02, '0, 3'b110);
      wk(5'h01, 5'h12, '0, 3'b000);
      wk(5'h04, 5'h0a, '0, 3'b011);
      wk(5'h00, 5'h01, 56'h1, 3'b100);
      wk(5'h01, 5'h01, '0, 3'b110);
      wk(5'h01, 5'h00, '0, 3'b100);
      rst();
      axr(8'h00, 32'hff, RESP_OKAY);
      print_verdict();
   end
endmodule : exception_vector_prioritizer_tb
